// ---- sysctl_exc_pkg.sv ----
// Package with the map, field layout, reset values and core-side carriers of the exception registers.
package sysctl_exc_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Register byte addresses.
  localparam logic [31:0] ADDR_AUX_DISABLE    = 32'he000e008;
  localparam logic [31:0] ADDR_PROC_ID        = 32'he000ed00;
  localparam logic [31:0] ADDR_INT_CTRL_STATE = 32'he000ed04;
  localparam logic [31:0] ADDR_VECTOR_TABLE   = 32'he000ed08;
  localparam logic [31:0] ADDR_APP_INT_RESET  = 32'he000ed0c;

  ////////////////////////////////////////////////////////////////////////////////
  // Auxiliary disable field positions.
  localparam int AUX_MCYC_BIT   = 0;
  localparam int AUX_DEFWB_BIT  = 1;
  localparam int AUX_FOLD_BIT   = 2;
  localparam int AUX_FPCTX_BIT  = 8;
  localparam int AUX_FPOOO_BIT  = 9;

  // Identification fields; every value below is arbitrary and names no maker.
  localparam logic [7:0]  ID_IMPLEMENTER = 8'h5a;
  localparam logic [3:0]  ID_VARIANT     = 4'h1;
  localparam logic [3:0]  ID_CONSTANT    = 4'h7;
  localparam logic [11:0] ID_PART_NUMBER = 12'h123;
  localparam logic [3:0]  ID_REVISION    = 4'h2;

  // Interrupt control and state field positions.
  localparam int ICS_NMI_SET_BIT   = 31;
  localparam int ICS_DS_SET_BIT    = 28;
  localparam int ICS_DS_CLR_BIT    = 27;
  localparam int ICS_TICK_SET_BIT  = 26;
  localparam int ICS_TICK_CLR_BIT  = 25;
  localparam int ICS_ISR_PEND_BIT  = 22;
  localparam int ICS_VPEND_LSB     = 12;
  localparam int ICS_RET_BASE_BIT  = 11;

  // Vector table offset field.
  localparam int VTO_LSB = 7;
  localparam int VTO_MSB = 29;

  // Application interrupt and reset control fields.
  localparam logic [15:0] AIR_WRITE_KEY    = 16'h05fa;
  localparam logic [15:0] AIR_READ_KEY     = 16'hfa05;
  localparam int          AIR_ENDIAN_BIT   = 15;
  localparam int          AIR_PRIGRP_LSB   = 8;
  localparam int          AIR_SYSRST_BIT   = 2;
  localparam logic        AIR_ENDIANNESS   = 1'b0;
  localparam logic [2:0]  AIR_PRIGRP_RESET = 3'h0;

  // Exception numbers of the system exceptions held here.
  localparam logic [8:0] EXC_NMI      = 9'h002;
  localparam logic [8:0] EXC_DEFERRED = 9'h00e;
  localparam logic [8:0] EXC_TICK     = 9'h00f;

  ////////////////////////////////////////////////////////////////////////////////
  // Disable controls steering the core pipeline.
  typedef struct packed {
    logic fp_out_of_order_disable;
    logic fp_context_update_disable;
    logic fold_disable;
    logic default_write_buffer_disable;
    logic multicycle_interrupt_disable;
  } aux_ctrl_t;

  // State reported by the core exception logic.
  typedef struct packed {
    logic [8:0] program_status_exception_bits;
    logic       preempted_active;
    logic       ext_any_pending;
    logic [8:0] ext_best_number;
    logic [7:0] ext_best_priority;
    logic [7:0] deferred_priority;
    logic [7:0] tick_priority;
    logic [7:0] base_priority_mask;
    logic       fault_mask_a;
  } core_status_t;

  // One-cycle handler entry pulses from the core.
  typedef struct packed {
    logic nmi_entry;
    logic deferred_entry;
    logic tick_entry;
  } exc_entry_t;

  // Pending system exceptions offered to the core.
  typedef struct packed {
    logic       nmi_pending;
    logic       deferred_pending;
    logic       tick_pending;
    logic [8:0] pending_vector_number;
  } exc_pending_t;

endpackage : sysctl_exc_pkg

// ---- system_control_exception_regs.sv ----
// System control exception registers: disable bits, identification, pending control, table, keyed control.
//
// Function
// (RQ1) Out-of-order floating point disable bit drives core control output.
// (RQ2) Floating point context disable bit stops automatic context flag updates.
// (RQ3) Fold disable bit stops overlapping the if-then instruction with its block.
// (RQ4) Default write buffer disable bit makes every default-map store complete first.
// (RQ5) Multi-cycle interruption disable bit keeps load/store multiple uninterrupted.
// (RQ6) Identification word: implementer, variant, constant, part number, revision fields.
// (RQ7) Writing 1 sets non-maskable pending; 0 ignored; read shows pending.
// (RQ8) Non-maskable handler entry clears pending; new assertion during handler sets it.
// (RQ9) Only a written 1 sets deferred service pending; read shows it.
// (RQ10) Writing 1 to deferred service clear bit removes pending; 0 ignored.
// (RQ11) Writing 1 sets tick pending; 0 ignored; read shows pending.
// (RQ12) Writing 1 to tick clear removes pending; bit reads zero.
// (RQ13) Interrupt pending flag shows any pending external interrupt only.
// (RQ14) Pending vector is best eligible exception under base priority, fault mask.
// (RQ15) Return-to-base flag is 0 while preempted active exceptions remain.
// (RQ16) Active vector reads core exception bits, zero in thread mode.
// (RQ17) Software never sets and clears the same pending bit together.
// (RQ18) Table offset holds bits 29:7; bit 29 selects code or SRAM.
// (RQ19) Table offset bits 6:0 are always zero.
// (RQ20) Control writes without the correct key are discarded whole.
// (RQ21) Control layout: key, endianness, grouping, reset request, two debug bits; the code has no debug bits, bits 1:0 read zero.
// (RQ22) Written reset request asserts system reset request; bit reads zero.
// (RQ23) Grouping splits priorities; only group part decides preemption.
// (RQ24) Reserved bits read zero and ignore writes.
`timescale 1ns/100ps
`default_nettype none

module system_control_exception_regs (
  input  wire logic                         CLK_SYS,
  input  wire logic                         RESETN,
  input  wire logic                         CE,
  input  wire logic                         PSEL,
  input  wire logic                         PENABLE,
  input  wire logic                         PWRITE,
  input  wire logic [31:0]                  PADDR,
  input  wire logic [31:0]                  PWDATA,
  output logic      [31:0]                  PRDATA,
  output logic                              PREADY,
  output logic                              PSLVERR,
  input  wire logic                         NMI_PIN,
  input  wire logic                         TICK_EVENT,
  input  wire sysctl_exc_pkg::core_status_t CORE_STATUS,
  input  wire sysctl_exc_pkg::exc_entry_t   EXC_ENTRY,
  output sysctl_exc_pkg::aux_ctrl_t         AUX_CTRL,
  output sysctl_exc_pkg::exc_pending_t      EXC_PENDING,
  output logic      [31:0]                  VECTOR_BASE,
  output logic      [2:0]                   PRIO_GROUP,
  output logic                              SYS_RESET_REQ
);
  import sysctl_exc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // Functions.

  // Keeps only the group part of a priority; the low bits are subpriority.
  function automatic logic [7:0] group_of(input logic [7:0] prio, input logic [2:0] grp);
    logic [7:0] mask;
    mask = 8'hff << (4'(grp) + 4'h1);
    return prio & mask;
  endfunction : group_of

  // True when a candidate may be taken despite base priority and fault mask.
  function automatic logic eligible(input logic [7:0] prio, input logic [2:0] grp,
                                    input logic [7:0] base, input logic fmask);
    return !fmask && ((base == 8'h00) || (group_of(prio, grp) < group_of(base, grp)));
  endfunction : eligible

  // True when candidate a outranks b: lower group priority, then lower number.
  function automatic logic outranks(input logic [7:0] pa, input logic [8:0] na,
                                    input logic [7:0] pb, input logic [8:0] nb,
                                    input logic [2:0] grp);
    logic [7:0] ga;
    logic [7:0] gb;
    ga = group_of(pa, grp);
    gb = group_of(pb, grp);
    return (ga < gb) || ((ga == gb) && (na < nb));
  endfunction : outranks

  ////////////////////////////////////////////////////////////////////////////////
  // Reset release and pin synchroniser.

  logic rst_meta;
  logic rst_n;
  logic nmi_meta;
  logic nmi_sync;
  logic nmi_prev;

  // The reset is applied at once but released only through two flops.
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // The pin is asynchronous; only the second flop and later are looked at.
  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      nmi_meta <= 1'b0;
      nmi_sync <= 1'b0;
      nmi_prev <= 1'b0;
    end else if (CE) begin
      nmi_meta <= NMI_PIN;
      nmi_sync <= nmi_meta;
      nmi_prev <= nmi_sync;
    end
  end

  logic nmi_rise;
  assign nmi_rise = nmi_sync & ~nmi_prev;

  ////////////////////////////////////////////////////////////////////////////////
  // Bus decode.

  logic setup_phase;
  logic access_phase;
  logic wr_strobe;
  logic addr_hit;

  // Reads are captured in the setup cycle so the data leaves a flop with one wait-free access.
  assign setup_phase  = CE & PSEL & ~PENABLE;
  assign access_phase = CE & PSEL & PENABLE;
  assign wr_strobe    = access_phase & PWRITE & addr_hit;

  // Misaligned or unmapped addresses miss and answer with an error.
  always_comb begin
    unique case (PADDR)
      ADDR_AUX_DISABLE, ADDR_PROC_ID, ADDR_INT_CTRL_STATE,
      ADDR_VECTOR_TABLE, ADDR_APP_INT_RESET: addr_hit = 1'b1;
      default:                               addr_hit = 1'b0;
    endcase
  end

  // Handshake: the access phase always completes, frozen only while CE is low.
  assign PREADY = access_phase;

  ////////////////////////////////////////////////////////////////////////////////
  // Register state.

  logic [4:0]  aux;
  logic        nmi_pend;
  logic        ds_pend;
  logic        tick_pend;
  logic [22:0] tbl_off;
  logic [2:0]  prio_grp;
  logic        sys_req;
  logic [31:0] rdata;
  logic        rerr;

  logic [4:0]  next_aux;
  logic        next_nmi_pend;
  logic        next_ds_pend;
  logic        next_tick_pend;
  logic [22:0] next_tbl_off;
  logic [2:0]  next_prio_grp;
  logic        next_sys_req;
  logic [31:0] next_rdata;
  logic        next_rerr;

  logic        wr_aux;
  logic        wr_ics;
  logic        wr_vto;
  logic        wr_air;
  logic        key_ok;
  logic [8:0]  vpend;
  logic [8:0]  active_num;

  assign wr_aux = wr_strobe && (PADDR == ADDR_AUX_DISABLE);
  assign wr_ics = wr_strobe && (PADDR == ADDR_INT_CTRL_STATE);
  assign wr_vto = wr_strobe && (PADDR == ADDR_VECTOR_TABLE);
  assign wr_air = wr_strobe && (PADDR == ADDR_APP_INT_RESET);
  assign key_ok = (PWDATA[31:16] == AIR_WRITE_KEY); // RQ20

  // Active number mirrors the core's exception bits; zero already means thread mode.
  assign active_num = CORE_STATUS.program_status_exception_bits; // RQ16

  ////////////////////////////////////////////////////////////////////////////////
  // Pending vector arbitration.

  // Non-maskable always wins; the others compete on group priority, then lower exception number.
  always_comb begin
    logic [7:0] best_p;
    logic [8:0] best_n;
    logic       found;
    best_p = 8'hff;
    best_n = 9'h000;
    found  = 1'b0;
    if (CORE_STATUS.ext_best_number != 9'h000 &&
        eligible(CORE_STATUS.ext_best_priority, prio_grp,
                 CORE_STATUS.base_priority_mask, CORE_STATUS.fault_mask_a)) begin // RQ14
      best_p = CORE_STATUS.ext_best_priority;
      best_n = CORE_STATUS.ext_best_number;
      found  = 1'b1;
    end
    if (tick_pend &&
        eligible(CORE_STATUS.tick_priority, prio_grp,
                 CORE_STATUS.base_priority_mask, CORE_STATUS.fault_mask_a) &&
        (!found || outranks(CORE_STATUS.tick_priority, EXC_TICK, best_p, best_n,
                            prio_grp))) begin // RQ23
      best_p = CORE_STATUS.tick_priority;
      best_n = EXC_TICK;
      found  = 1'b1;
    end
    if (ds_pend &&
        eligible(CORE_STATUS.deferred_priority, prio_grp,
                 CORE_STATUS.base_priority_mask, CORE_STATUS.fault_mask_a) &&
        (!found || outranks(CORE_STATUS.deferred_priority, EXC_DEFERRED, best_p, best_n,
                            prio_grp))) begin // RQ23
      best_p = CORE_STATUS.deferred_priority;
      best_n = EXC_DEFERRED;
      found  = 1'b1;
    end
    vpend = nmi_pend ? EXC_NMI : (found ? best_n : 9'h000); // RQ14
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Next-state logic for all registers.

  // Hardware sets are applied after software and entry clears, so a set in the
  // same cycle as a clear is never lost.
  always_comb begin
    next_aux       = aux;
    next_nmi_pend  = nmi_pend;
    next_ds_pend   = ds_pend;
    next_tick_pend = tick_pend;
    next_tbl_off   = tbl_off;
    next_prio_grp  = prio_grp;
    next_sys_req   = sys_req;
    next_rdata     = rdata;
    next_rerr      = rerr;

    if (wr_aux) begin
      next_aux = {PWDATA[AUX_FPOOO_BIT], PWDATA[AUX_FPCTX_BIT], PWDATA[AUX_FOLD_BIT],
                  PWDATA[AUX_DEFWB_BIT], PWDATA[AUX_MCYC_BIT]}; // RQ24
    end

    // Clears first: handler entry and written clear bits.
    if (EXC_ENTRY.nmi_entry) begin
      next_nmi_pend = 1'b0; // RQ8
    end
    if (EXC_ENTRY.deferred_entry || (wr_ics && PWDATA[ICS_DS_CLR_BIT])) begin
      next_ds_pend = 1'b0; // RQ10
    end
    if (EXC_ENTRY.tick_entry || (wr_ics && PWDATA[ICS_TICK_CLR_BIT])) begin
      next_tick_pend = 1'b0; // RQ12
    end

    // Sets last; a set and clear in one write leaves the bit set.
    if ((wr_ics && PWDATA[ICS_NMI_SET_BIT]) || nmi_rise) begin
      next_nmi_pend = 1'b1; // RQ7 RQ8
    end
    if (wr_ics && PWDATA[ICS_DS_SET_BIT]) begin
      next_ds_pend = 1'b1; // RQ9 RQ17
    end
    if ((wr_ics && PWDATA[ICS_TICK_SET_BIT]) || TICK_EVENT) begin
      next_tick_pend = 1'b1; // RQ11 RQ17
    end

    if (wr_vto) begin
      next_tbl_off = PWDATA[VTO_MSB:VTO_LSB]; // RQ18 RQ19
    end

    // A wrong key discards the whole write, reset request included.
    if (wr_air && key_ok) begin // RQ20
      next_prio_grp = PWDATA[AIR_PRIGRP_LSB +: 3]; // RQ21
      if (PWDATA[AIR_SYSRST_BIT]) begin
        next_sys_req = 1'b1; // RQ22
      end
    end

    // Read data and error are captured in the setup cycle.
    if (setup_phase) begin
      next_rerr  = ~addr_hit;
      next_rdata = 32'h0000_0000;
      if (!PWRITE) begin
        unique case (PADDR)
          ADDR_AUX_DISABLE: begin
            next_rdata[AUX_FPOOO_BIT] = aux[4];
            next_rdata[AUX_FPCTX_BIT] = aux[3];
            next_rdata[AUX_FOLD_BIT]  = aux[2];
            next_rdata[AUX_DEFWB_BIT] = aux[1];
            next_rdata[AUX_MCYC_BIT]  = aux[0];
          end
          ADDR_PROC_ID: begin
            next_rdata = {ID_IMPLEMENTER, ID_VARIANT, ID_CONSTANT, ID_PART_NUMBER,
                          ID_REVISION}; // RQ6
          end
          ADDR_INT_CTRL_STATE: begin
            next_rdata[ICS_NMI_SET_BIT]          = nmi_pend; // RQ7
            next_rdata[ICS_DS_SET_BIT]           = ds_pend; // RQ9
            next_rdata[ICS_TICK_SET_BIT]         = tick_pend; // RQ11
            next_rdata[ICS_ISR_PEND_BIT]         = CORE_STATUS.ext_any_pending; // RQ13
            next_rdata[ICS_VPEND_LSB +: 9]       = vpend; // RQ14
            next_rdata[ICS_RET_BASE_BIT]         = ~CORE_STATUS.preempted_active; // RQ15
            next_rdata[8:0]                      = active_num; // RQ16
          end
          ADDR_VECTOR_TABLE: begin
            next_rdata[VTO_MSB:VTO_LSB] = tbl_off; // RQ19
          end
          ADDR_APP_INT_RESET: begin
            next_rdata[31:16]                 = AIR_READ_KEY;
            next_rdata[AIR_ENDIAN_BIT]        = AIR_ENDIANNESS;
            next_rdata[AIR_PRIGRP_LSB +: 3]   = prio_grp; // RQ21
          end
          default: begin
            next_rdata = 32'h0000_0000; // RQ24
          end
        endcase
      end
    end
  end

  // Registers only; CE low freezes every bit.
  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      aux       <= 5'h00;
      nmi_pend  <= 1'b0;
      ds_pend   <= 1'b0;
      tick_pend <= 1'b0;
      tbl_off   <= 23'h000000;
      prio_grp  <= AIR_PRIGRP_RESET;
      sys_req   <= 1'b0;
      rdata     <= 32'h0000_0000;
      rerr      <= 1'b0;
    end else if (CE) begin
      aux       <= next_aux;
      nmi_pend  <= next_nmi_pend;
      ds_pend   <= next_ds_pend;
      tick_pend <= next_tick_pend;
      tbl_off   <= next_tbl_off;
      prio_grp  <= next_prio_grp;
      sys_req   <= next_sys_req;
      rdata     <= next_rdata;
      rerr      <= next_rerr;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs.

  assign PRDATA  = rdata;
  assign PSLVERR = PREADY & rerr;

  // The disable controls go straight to the pipeline.
  assign AUX_CTRL.fp_out_of_order_disable      = aux[4]; // RQ1
  assign AUX_CTRL.fp_context_update_disable    = aux[3]; // RQ2
  assign AUX_CTRL.fold_disable                 = aux[2]; // RQ3
  assign AUX_CTRL.default_write_buffer_disable = aux[1]; // RQ4
  assign AUX_CTRL.multicycle_interrupt_disable = aux[0]; // RQ5

  assign EXC_PENDING.nmi_pending           = nmi_pend;
  assign EXC_PENDING.deferred_pending      = ds_pend;
  assign EXC_PENDING.tick_pending          = tick_pend;
  assign EXC_PENDING.pending_vector_number = vpend; // RQ14

  // Low seven bits of the base are tied to zero by construction.
  assign VECTOR_BASE = {2'b00, tbl_off, 7'h00}; // RQ18 RQ19
  assign PRIO_GROUP  = prio_grp; // RQ23

  // The request holds until the system reset it asks for arrives.
  assign SYS_RESET_REQ = sys_req; // RQ22

endmodule : system_control_exception_regs

`default_nettype wire

// ---- sysctl_exc_chk.sv ----
// Port checker for the exception register block, bound to its top module.
`timescale 1ns/100ps
`default_nettype none

module sysctl_exc_chk
  import sysctl_exc_pkg::*;
(
  input wire logic                         CLK_SYS,
  input wire logic                         RESETN,
  input wire logic                         PWRITE,
  input wire logic [31:0]                  PADDR,
  input wire logic [31:0]                  PWDATA,
  input wire logic [31:0]                  PRDATA,
  input wire logic                         PREADY,
  input wire sysctl_exc_pkg::aux_ctrl_t    AUX_CTRL,
  input wire sysctl_exc_pkg::exc_pending_t EXC_PENDING,
  input wire logic [31:0]                  VECTOR_BASE,
  input wire logic [2:0]                   PRIO_GROUP,
  input wire logic                         SYS_RESET_REQ
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RESETN);

  ////////////////////////////////////////////////////////////////////////////////
  // Completed transfers; the ready term already carries select, enable and clock enable.
  logic wr;
  logic rd;
  logic ics_wr;
  logic air_wr;
  assign wr     = PREADY && PWRITE;
  assign rd     = PREADY && !PWRITE;
  assign ics_wr = wr && (PADDR == ADDR_INT_CTRL_STATE);
  assign air_wr = wr && (PADDR == ADDR_APP_INT_RESET);

  ////////////////////////////////////////////////////////////////////////////////
  a_ident_word:
    assert property (rd && PADDR == ADDR_PROC_ID |-> PRDATA == {ID_IMPLEMENTER, ID_VARIANT,
      ID_CONSTANT, ID_PART_NUMBER, ID_REVISION}) else $error("identification word wrong");
  a_aux_update:
    assert property (wr && PADDR == ADDR_AUX_DISABLE |=>
      AUX_CTRL == {$past(PWDATA[9:8]), $past(PWDATA[2:0])}) else $error("disable bits wrong");
  a_nmi_set:
    assert property (ics_wr && PWDATA[31] |=> EXC_PENDING.nmi_pending) else $error("nmi not set");
  a_ds_only_write:
    assert property ($rose(EXC_PENDING.deferred_pending) |-> $past(ics_wr && PWDATA[28]))
      else $error("deferred pending without write");
  a_ds_clear:
    assert property (ics_wr && PWDATA[27] && !PWDATA[28] |=> !EXC_PENDING.deferred_pending)
      else $error("deferred not cleared");
  a_tick_set:
    assert property (ics_wr && PWDATA[26] |=> EXC_PENDING.tick_pending) else $error("tick not set");
  a_key_discard:
    assert property (air_wr && PWDATA[31:16] != AIR_WRITE_KEY |=> $stable(PRIO_GROUP)
      && $stable(SYS_RESET_REQ)) else $error("unkeyed write took effect");
  a_reset_req:
    assert property (air_wr && PWDATA[31:16] == AIR_WRITE_KEY && PWDATA[2] |=> SYS_RESET_REQ)
      else $error("reset request missing");
  a_table_base:
    assert property (wr && PADDR == ADDR_VECTOR_TABLE |=>
      VECTOR_BASE == {2'b00, $past(PWDATA[29:7]), 7'h00}) else $error("table base wrong");
  a_ctrl_read:
    assert property (rd && PADDR == ADDR_APP_INT_RESET |-> PRDATA == {AIR_READ_KEY,
      AIR_ENDIANNESS, 4'h0, PRIO_GROUP, 8'h00}) else $error("control read wrong");

endmodule : sysctl_exc_chk

bind system_control_exception_regs sysctl_exc_chk u_chk (
  .CLK_SYS, .RESETN, .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY,
  .AUX_CTRL, .EXC_PENDING, .VECTOR_BASE, .PRIO_GROUP, .SYS_RESET_REQ
);
`default_nettype wire

// ---- core_model.sv ----
// Behavioural core that takes pending system exceptions and reports its state.
`timescale 1ns/100ps
`default_nettype none

module core_model
  import sysctl_exc_pkg::*;
(
  input  wire logic                         clk,
  input  wire logic                         take,
  input  wire logic                         mask,
  input  wire sysctl_exc_pkg::exc_pending_t pend,
  output var  sysctl_exc_pkg::core_status_t status,
  output var  sysctl_exc_pkg::exc_entry_t   entry
);
  // Zero priorities and no external candidate; mask raises the fault mask and an outside pending flag.
  initial begin
    status = '0;
    entry  = '0;
  end

  // On a take request the most urgent pending exception is entered for one pulse.
  always @(posedge clk) begin
    entry <= '0;
    status.fault_mask_a    <= mask;
    status.ext_any_pending <= mask;
    if (take && (pend.nmi_pending || pend.deferred_pending || pend.tick_pending)) begin
      entry <= {pend.nmi_pending, !pend.nmi_pending && pend.deferred_pending,
                !pend.nmi_pending && !pend.deferred_pending};
      status.preempted_active <= status.program_status_exception_bits != 9'h000;
      status.program_status_exception_bits <= pend.nmi_pending ? EXC_NMI :
        (pend.deferred_pending ? EXC_DEFERRED : EXC_TICK);
    end
  end
endmodule : core_model
`default_nettype wire

// ---- tb.sv ----
// Self-checking bench for the exception register block.
`timescale 1ns/100ps
`default_nettype none

module tb;
  import sysctl_exc_pkg::*;
  localparam logic [32:0] ICS_M = 33'h1fdffffff;
  logic         clk_sys, resetn, psel, penable, pwrite, nmi_pin, tick_event, take, ce, mask;
  logic         pready, pslverr, rst_req;
  logic [31:0]  paddr, pwdata, prdata, vbase, lfsr;
  logic [2:0]   pgrp;
  core_status_t status;
  exc_entry_t   entry;
  aux_ctrl_t    aux;
  exc_pending_t pend;
  logic [32:0]  exp_q[$];
  logic [32:0]  msk_q[$];
  int           fail_count, n_checks;

  system_control_exception_regs dut (.CLK_SYS(clk_sys), .RESETN(resetn), .CE(ce),
    .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .NMI_PIN(nmi_pin),
    .TICK_EVENT(tick_event), .CORE_STATUS(status), .EXC_ENTRY(entry), .AUX_CTRL(aux),
    .EXC_PENDING(pend), .VECTOR_BASE(vbase), .PRIO_GROUP(pgrp), .SYS_RESET_REQ(rst_req));
  core_model u_core (.clk(clk_sys), .take(take), .mask(mask), .pend(pend), .status(status),
    .entry(entry));

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next

  task automatic chk(input logic [32:0] got, input logic [32:0] ex, input logic [32:0] m);
    n_checks++;
    if ((got & m) !== (ex & m)) begin
      fail_count++;
      $display("BAD %0t got %h expected %h", $time, got, ex);
    end
  endtask : chk

  // One APB transfer; a read notes its expected error flag and data for the monitor.
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d,
                     input logic [32:0] ex = '0, input logic [32:0] m = '0);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    if (!w) begin
      exp_q.push_back(ex);
      msk_q.push_back(m);
    end
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask : apb

  // One stimulus (status write, take, NMI pin or tick event), then a read after the pending logic settles.
  task automatic ics_step(input logic [1:0] act, input logic [31:0] wd, input logic [31:0] ex);
    case (act)
      2'd0: apb(1'b1, ADDR_INT_CTRL_STATE, wd);
      2'd1: take <= 1'b1;
      2'd2: nmi_pin <= 1'b1;
      default: tick_event <= 1'b1;
    endcase
    @(posedge clk_sys);
    take       <= 1'b0;
    tick_event <= 1'b0;
    ce         <= 1'b1;
    repeat (4) @(posedge clk_sys);
    apb(1'b0, ADDR_INT_CTRL_STATE, '0, {1'b0, ex}, ICS_M);
    chk({24'h0, EXC_PENDING_VEC(pend)}, {24'h0, ex[20:12]}, '1);
  endtask : ics_step

  // Pending vector output, read straight off the port.
  function automatic logic [8:0] EXC_PENDING_VEC(input exc_pending_t p);
    return p.pending_vector_number;
  endfunction : EXC_PENDING_VEC

  task automatic complete_run();
    if (fail_count == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : complete_run

  ////////////////////////////////////////////////////////////////////////////////
  // The monitor samples before this edge's updates land, so read data is settled.
  always @(posedge clk_sys) begin
    if (psel && penable && pready && !pwrite && exp_q.size() > 0) begin
      chk({pslverr, prdata}, exp_q.pop_front(), msk_q.pop_front());
    end
  end

  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  // A hang ends the run with a counted mismatch.
  initial begin
    #200000;
    fail_count++;
    complete_run();
  end

  initial begin
    {resetn, psel, penable, pwrite, nmi_pin, tick_event, take, mask} = '0;
    ce = 1'b1;
    paddr = '0;
    pwdata = '0;
    lfsr = 32'h00016377;
    repeat (6) @(posedge clk_sys);
    resetn <= 1'b1;
    repeat (3) @(posedge clk_sys);
    apb(1'b0, ADDR_AUX_DISABLE, '0, '0, '1);
    apb(1'b0, ADDR_PROC_ID, '0, {1'b0, ID_IMPLEMENTER, ID_VARIANT, ID_CONSTANT,
        ID_PART_NUMBER, ID_REVISION}, '1);
    apb(1'b0, ADDR_INT_CTRL_STATE, '0, 33'h000000800, ICS_M);
    apb(1'b0, ADDR_VECTOR_TABLE, '0, '0, '1);
    apb(1'b0, ADDR_APP_INT_RESET, '0, {1'b0, AIR_READ_KEY, 16'h0000}, '1);
    apb(1'b0, 32'he000ed80, '0, 33'h100000000, '1);
    for (int i = 0; i < 4; i++) begin
      lfsr = lfsr_next(lfsr);
      apb(1'b1, ADDR_AUX_DISABLE, lfsr);
      apb(1'b0, ADDR_AUX_DISABLE, '0, {1'b0, lfsr & 32'h00000307}, '1);
      chk({28'h0, aux}, {28'h0, lfsr[9:8], lfsr[2:0]}, '1);
      apb(1'b1, ADDR_VECTOR_TABLE, lfsr);
      apb(1'b0, ADDR_VECTOR_TABLE, '0, {1'b0, lfsr & 32'h3fffff80}, '1);
      chk({1'b0, vbase}, {1'b0, lfsr & 32'h3fffff80}, '1);
    end
    ics_step(2'd0, 32'h10000000, 32'h1000e800);
    ics_step(2'd0, 32'h04000000, 32'h1400e800);
    ics_step(2'd0, 32'h00000000, 32'h1400e800);
    ics_step(2'd0, 32'h08000000, 32'h0400f800);
    mask <= 1'b1;
    ics_step(2'd0, 32'h00000000, 32'h04400800);
    mask <= 1'b0;
    ics_step(2'd0, 32'h02000000, 32'h00000800);
    ce <= 1'b0;
    ics_step(2'd3, 32'h00000000, 32'h00000800);
    ics_step(2'd0, 32'h10000000, 32'h1000e800);
    ics_step(2'd1, 32'h00000000, 32'h0000080e);
    ics_step(2'd0, 32'h80000000, 32'h8000280e);
    ics_step(2'd1, 32'h00000000, 32'h00000002);
    ics_step(2'd2, 32'h00000000, 32'h80002002);
    ics_step(2'd3, 32'h00000000, 32'h84002002);
    apb(1'b1, ADDR_APP_INT_RESET, 32'h12340504);
    apb(1'b0, ADDR_APP_INT_RESET, '0, {1'b0, AIR_READ_KEY, 16'h0000}, '1);
    chk({32'h0, rst_req}, '0, '1);
    for (int g = 0; g < 8; g++) begin
      apb(1'b1, ADDR_APP_INT_RESET, {AIR_WRITE_KEY, 5'h00, 3'(g), 8'h00});
      apb(1'b0, ADDR_APP_INT_RESET, '0, {1'b0, AIR_READ_KEY, 5'h00, 3'(g), 8'h00}, '1);
      chk({30'h0, pgrp}, 33'(g), '1);
    end
    apb(1'b1, ADDR_APP_INT_RESET, {AIR_WRITE_KEY, 16'h0004});
    apb(1'b0, ADDR_APP_INT_RESET, '0, {1'b0, AIR_READ_KEY, 16'h0000}, '1);
    chk({32'h0, rst_req}, 33'h1, '1);
    complete_run();
  end
endmodule : tb
`default_nettype wire
